// File: rtl/dicr_regs.sv
// input receiver config, delay/reference control and alarm status bank
// assumes AHB-Lite master on hclk and synchronous status inputs
`timescale 1ns/10ps
`include "dicr_defs.svh"

module dicr_regs
  import dicr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [13:0] test_fail_bits,
  input  wire logic [7:0]  fifo_a_wr_ptr,
  input  wire logic [7:0]  fifo_b_wr_ptr,
  input  wire logic        fifo_a_two_apart,
  input  wire logic        fifo_a_one_apart,
  input  wire logic        fifo_a_collision,
  input  wire logic        fifo_b_two_apart,
  input  wire logic        fifo_b_one_apart,
  input  wire logic        fifo_b_collision,
  output logic [13:0]      receiver_enable,
  output dicr_delay_t      data_delay_a,
  output dicr_delay_t      clk_delay_a,
  output dicr_delay_t      data_delay_b,
  output dicr_delay_t      clk_delay_b,
  output logic             ext_ref_select,
  output logic             dual_clock_enable,
  output logic             iotest_enable,
  output logic             two_apart_alarm_enable,
  output logic             one_apart_alarm_enable,
  output logic             collision_alarm_enable
);

  logic       rd_take;
  dicr_sel_t  rd_sel;
  logic       wr_pend;
  dicr_sel_t  wr_sel;
  dicr_word_t wdata;

  dicr_word_t ctrl;
  dicr_word_t rxen;
  dicr_word_t dly;
  dicr_word_t next_ctrl;
  dicr_word_t next_rxen;
  dicr_word_t next_dly;

  logic [13:0] test_set;
  logic [13:0] test_clr;
  logic [13:0] test_q;
  logic [7:0]  alarm_set;
  logic [7:0]  alarm_clr;
  logic [7:0]  alarm_q;
  logic [2:0]  ptr_set_a;
  logic [2:0]  ptr_set_b;
  logic        hit_ctrl;
  logic        hit_rxen;
  logic        hit_dly;
  logic        hit_test;
  logic        hit_alarm;
  logic        zero_a;
  logic        zero_b;

  dicr_word_t  rd_word;
  logic [31:0] next_hrdata;

  // combine one FIFO's pointer events under the shared enables
  function automatic logic [2:0] ptr_code(input logic two,
                                          input logic one,
                                          input logic coll,
                                          input logic [15:0] c);
    logic [2:0] r;
    r = 3'b000;
    r[`DICR_PTR_TWO_BIT]  = two  && c[`DICR_CTRL_TWO_BIT];
    r[`DICR_PTR_ONE_BIT]  = one  && c[`DICR_CTRL_ONE_BIT];
    r[`DICR_PTR_COLL_BIT] = coll && c[`DICR_CTRL_COLL_BIT];
    return r;
  endfunction

  // masked write of a read/write register
  function automatic dicr_word_t rw_update(input dicr_word_t cur,
                                           input dicr_word_t wd,
                                           input dicr_word_t mask,
                                           input logic       hit);
    dicr_word_t r;
    r = cur;
    if (hit) begin
      r = wd & mask;
    end
    return r;
  endfunction

  // data phase write strobe of one register
  function automatic logic wr_hit(input logic      pend,
                                  input dicr_sel_t have,
                                  input dicr_sel_t want);
    return pend && (have == want);
  endfunction

  // one-hot pointer that has lost its token
  function automatic logic ptr_lost(input logic [`DICR_WPTR_W-1:0] p);
    return p == '0;
  endfunction

  dicr_ahb_front u_front (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hready  (hready),
    .rd_take (rd_take),
    .rd_sel  (rd_sel),
    .wr_pend (wr_pend),
    .wr_sel  (wr_sel)
  );

  // zero wait state, always OKAY
  always_comb begin
    hreadyout = 1'b1;
    hresp     = 1'b0;
    wdata     = hwdata[15:0];
  end

  // write strobes, valid in the data phase only
  always_comb begin
    hit_ctrl  = wr_hit(wr_pend, wr_sel, DICR_SEL_CTRL);
    hit_rxen  = wr_hit(wr_pend, wr_sel, DICR_SEL_RXEN);
    hit_dly   = wr_hit(wr_pend, wr_sel, DICR_SEL_DLY);
    hit_test  = wr_hit(wr_pend, wr_sel, DICR_SEL_TEST);
    hit_alarm = wr_hit(wr_pend, wr_sel, DICR_SEL_ALARM);
  end

  // control register: test and alarm enables
  always_comb begin
    next_ctrl = rw_update(ctrl, wdata, `DICR_CTRL_MASK, hit_ctrl);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `DICR_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // receiver enables
  always_comb begin
    next_rxen = rw_update(rxen, wdata, `DICR_RXEN_MASK, hit_rxen);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxen <= `DICR_RXEN_RESET;
    end else begin
      rxen <= next_rxen;
    end
  end

  // delay and reference register
  always_comb begin
    next_dly = rw_update(dly, wdata, `DICR_DLY_MASK, hit_dly);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly <= `DICR_DLY_RESET;
    end else begin
      dly <= next_dly;
    end
  end

  // receiver enable outputs
  always_comb begin
    receiver_enable = rxen[`DICR_RXEN_MSB:0];
  end

  // delay and reference outputs
  always_comb begin
    data_delay_a      = dly[`DICR_DLY_DATA_A_LSB +: 3];
    clk_delay_a       = dly[`DICR_DLY_CLK_A_LSB +: 3];
    data_delay_b      = dly[`DICR_DLY_DATA_B_LSB +: 3];
    clk_delay_b       = dly[`DICR_DLY_CLK_B_LSB +: 3];
    ext_ref_select    = dly[`DICR_DLY_EXTREF_BIT];
    dual_clock_enable = dly[`DICR_DLY_DUAL_BIT];
  end

  // enables for the test comparator and alarm logic
  always_comb begin
    iotest_enable          = ctrl[`DICR_CTRL_IOTEST_BIT];
    two_apart_alarm_enable = ctrl[`DICR_CTRL_TWO_BIT];
    one_apart_alarm_enable = ctrl[`DICR_CTRL_ONE_BIT];
    collision_alarm_enable = ctrl[`DICR_CTRL_COLL_BIT];
  end

  // pattern test failures
  always_comb begin
    test_set = iotest_enable ? test_fail_bits : 14'h0000;
    test_clr = hit_test ? wdata[`DICR_TEST_MSB:0] : 14'h0000;
  end

  dicr_w1c_bits #(
    .W (14)
  ) u_test (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (test_set),
    .clr     (test_clr),
    .q       (test_q)
  );

  always_comb begin
    zero_a = ptr_lost(fifo_a_wr_ptr);
    zero_b = ptr_lost(fifo_b_wr_ptr);
  end

  // FIFO alarms, packed as register bits 15:8
  always_comb begin
    ptr_set_a = ptr_code(fifo_a_two_apart, fifo_a_one_apart,
                         fifo_a_collision, ctrl);
    ptr_set_b = ptr_code(fifo_b_two_apart, fifo_b_one_apart,
                         fifo_b_collision, ctrl);
    alarm_set = 8'h00;
    alarm_set[`DICR_ALM_ZERO_A_BIT - 8] = zero_a;
    alarm_set[`DICR_ALM_ZERO_B_BIT - 8] = zero_b;
    alarm_set[`DICR_ALM_PTR_A_LSB - 8 +: 3] = ptr_set_a;
    alarm_set[`DICR_ALM_PTR_B_LSB - 8 +: 3] = ptr_set_b;
    alarm_clr = hit_alarm ? wdata[15:8] : 8'h00;
  end

  dicr_w1c_bits #(
    .W (8)
  ) u_alarm (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (alarm_set),
    .clr     (alarm_clr),
    .q       (alarm_q)
  );

  // read mux, sampled at the end of the address phase
  // a read whose address phase is a write's data phase sees the old value
  always_comb begin
    rd_word = 16'h0000;
    unique case (rd_sel)
      DICR_SEL_CTRL:  rd_word = ctrl;
      DICR_SEL_RXEN:  rd_word = rxen;
      DICR_SEL_DLY:   rd_word = dly;
      DICR_SEL_TEST:  rd_word = {2'b00, test_q};
      DICR_SEL_ALARM: rd_word = {alarm_q, 8'h00};
      DICR_SEL_NONE:  rd_word = 16'h0000;
    endcase
    // upper half and unmapped read zero
    next_hrdata = rd_take ? {16'h0000, rd_word} : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

endmodule

// File: rtl/dicr_defs.svh
// register indices, field positions and reset values of the input config bank
// assumes inclusion by bare name from design files
`ifndef DICR_DEFS_SVH
`define DICR_DEFS_SVH

// register indices; byte address is four times the index
`define DICR_IDX_CTRL        4'h1
`define DICR_IDX_RXEN        4'h2
`define DICR_IDX_DLY         4'h3
`define DICR_IDX_TEST        4'h4
`define DICR_IDX_ALARM       4'h5

// control register fields
`define DICR_CTRL_IOTEST_BIT 15
`define DICR_CTRL_TWO_BIT    3
`define DICR_CTRL_ONE_BIT    2
`define DICR_CTRL_COLL_BIT   1
`define DICR_CTRL_MASK       16'h800e
`define DICR_CTRL_RESET      16'h000e

// receiver enable register
`define DICR_RXEN_MSB        13
`define DICR_RXEN_MASK       16'h3fff
`define DICR_RXEN_RESET      16'h3fff

// delay and reference register
`define DICR_DLY_DATA_A_LSB  13
`define DICR_DLY_CLK_A_LSB   10
`define DICR_DLY_DATA_B_LSB  7
`define DICR_DLY_CLK_B_LSB   4
`define DICR_DLY_EXTREF_BIT  3
`define DICR_DLY_DUAL_BIT    0
`define DICR_DLY_MASK        16'hfff9
`define DICR_DLY_RESET       16'h0000

// test result register
`define DICR_TEST_MSB        13
`define DICR_TEST_RESET      14'h0000

// alarm register
`define DICR_ALM_ZERO_A_BIT  15
`define DICR_ALM_ZERO_B_BIT  14
`define DICR_ALM_PTR_A_LSB   11
`define DICR_ALM_PTR_B_LSB   8
`define DICR_ALM_RESET       8'h00

// pointer state code bits
`define DICR_PTR_TWO_BIT     0
`define DICR_PTR_ONE_BIT     1
`define DICR_PTR_COLL_BIT    2

`define DICR_WPTR_W          8

`endif

// File: rtl/dicr_pkg.sv
// types shared by the input config and alarm register bank
// assumes the constants of dicr_defs.svh
package dicr_pkg;

  typedef logic [2:0]  dicr_delay_t;
  typedef logic [15:0] dicr_word_t;

  typedef enum logic [2:0] {
    DICR_SEL_NONE,
    DICR_SEL_CTRL,
    DICR_SEL_RXEN,
    DICR_SEL_DLY,
    DICR_SEL_TEST,
    DICR_SEL_ALARM
  } dicr_sel_t;

endpackage

// File: rtl/dicr_ahb_front.sv
// AHB-Lite address phase capture for the register bank
// assumes single word transfers and one slave on the bus
`timescale 1ns/10ps
`include "dicr_defs.svh"
module dicr_ahb_front
  import dicr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             rd_take,
  output dicr_sel_t        rd_sel,
  output logic             wr_pend,
  output dicr_sel_t        wr_sel
);

  logic      take;
  dicr_sel_t sel;
  logic      next_wr_pend;
  dicr_sel_t next_wr_sel;

  function automatic dicr_sel_t decode(input logic [31:0] a);
    dicr_sel_t s;
    s = DICR_SEL_NONE;
    if (a[31:6] == 26'h0 && a[1:0] == 2'b00) begin
      unique case (a[5:2])
        `DICR_IDX_CTRL:  s = DICR_SEL_CTRL;
        `DICR_IDX_RXEN:  s = DICR_SEL_RXEN;
        `DICR_IDX_DLY:   s = DICR_SEL_DLY;
        `DICR_IDX_TEST:  s = DICR_SEL_TEST;
        `DICR_IDX_ALARM: s = DICR_SEL_ALARM;
        default:         s = DICR_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  always_comb begin
    take         = hsel && htrans[1] && hready;
    sel          = decode(haddr);
    rd_take      = take && !hwrite;
    rd_sel       = sel;
    next_wr_pend = take && hwrite;
    next_wr_sel  = take ? sel : wr_sel;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_sel  <= DICR_SEL_NONE;
    end else begin
      wr_pend <= next_wr_pend;
      wr_sel  <= next_wr_sel;
    end
  end

endmodule

// File: rtl/dicr_w1c_bits.sv
// sticky status bits, cleared by writing one, hardware set wins
// assumes set and clear are single cycle strobes on hclk
`timescale 1ns/10ps
module dicr_w1c_bits
  import dicr_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  logic [W-1:0] next_q;

  always_comb begin
    next_q = (q & ~clr) | set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

// File: tb/dicr_regs_props.sv
// assertions on the ports of the input config and alarm register bank
// assumes hready is looped back from hreadyout on a one slave bus
`timescale 1ns/10ps
module dicr_regs_props
  import dicr_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic [13:0] test_fail_bits,
  input wire logic [7:0]  fifo_a_wr_ptr,
  input wire logic [7:0]  fifo_b_wr_ptr,
  input wire logic        fifo_a_collision,
  input wire logic [13:0] receiver_enable,
  input wire dicr_delay_t data_delay_a,
  input wire dicr_delay_t clk_delay_a,
  input wire dicr_delay_t data_delay_b,
  input wire dicr_delay_t clk_delay_b,
  input wire logic        ext_ref_select,
  input wire logic        dual_clock_enable,
  input wire logic        iotest_enable,
  input wire logic        collision_alarm_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // address phase taken by the slave
  sequence s_req(logic w, logic [31:0] a);
    hsel && hready && htrans[1] && (hwrite == w) && (haddr == a);
  endsequence

  chk_rxen_reset: assert property (
    $rose(hresetn) |-> receiver_enable == 14'h3fff) else $error("receiver enables not all set");
  chk_rxen_write: assert property (
    s_req(1'b1, 32'h0000_0008) ##1 1'b1 |=> receiver_enable == $past(hwdata[13:0]))
    else $error("receiver enables not written");
  chk_dly_write: assert property (
    s_req(1'b1, 32'h0000_000c) ##1 1'b1 |=> {data_delay_a, clk_delay_a, data_delay_b,
    clk_delay_b, ext_ref_select, dual_clock_enable} == {$past(hwdata[15:3]), $past(hwdata[0])})
    else $error("delay fields not written");
  chk_rsvd_zero: assert property (
    s_req(1'b0, 32'h0000_0008) |=> hrdata[31:14] == 18'h0_0000) else $error("reserved bits set");
  chk_unmapped_zero: assert property (
    s_req(1'b0, 32'h0000_0040) |=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  chk_test_flag: assert property (
    s_req(1'b0, 32'h0000_0010) ##0 ($past(test_fail_bits[13]) && $past(iotest_enable))
    |=> hrdata[13]) else $error("test failure not flagged");
  chk_zero_a: assert property (
    s_req(1'b0, 32'h0000_0014) ##0 ($past(hresetn) && $past(fifo_a_wr_ptr) == 8'h00)
    |=> hrdata[15]) else $error("stuck pointer a not flagged");
  chk_zero_b: assert property (
    s_req(1'b0, 32'h0000_0014) ##0 ($past(hresetn) && $past(fifo_b_wr_ptr) == 8'h00)
    |=> hrdata[14]) else $error("stuck pointer b not flagged");
  chk_coll_flag: assert property (
    s_req(1'b0, 32'h0000_0014) ##0 ($past(fifo_a_collision) && $past(collision_alarm_enable))
    |=> hrdata[13]) else $error("collision not flagged");
endmodule

bind dicr_regs dicr_regs_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hwdata, .hrdata, .test_fail_bits, .fifo_a_wr_ptr, .fifo_b_wr_ptr,
  .fifo_a_collision, .receiver_enable, .data_delay_a, .clk_delay_a, .data_delay_b,
  .clk_delay_b, .ext_ref_select, .dual_clock_enable, .iotest_enable, .collision_alarm_enable);

// File: tb/dicr_regs_tb.sv
// self-checking bench for the input config and alarm register bank
// assumes the bank is the only slave, hready looped back from hreadyout
`timescale 1ns/10ps
module dicr_regs_tb
  import dicr_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rdat;
  logic        hreadyout, hresp;
  logic [13:0] test_fail_bits = 14'h0000;
  logic [7:0]  fifo_a_wr_ptr = 8'h01;
  logic [7:0]  fifo_b_wr_ptr = 8'h01;
  logic [5:0]  ev = 6'h00;
  logic [13:0] receiver_enable;
  dicr_delay_t data_delay_a, clk_delay_a, data_delay_b, clk_delay_b;
  logic        ext_ref_select, dual_clock_enable, iotest_enable;
  logic        two_apart_alarm_enable, one_apart_alarm_enable, collision_alarm_enable;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [31:0] ra [5] = '{32'h0000_0004, 32'h0000_0008, 32'h0000_000c, 32'h0000_0010,
                          32'h0000_0014};
  logic [31:0] rv [5] = '{32'h0000_000e, 32'h0000_3fff, 32'h0000_0000, 32'h0000_0000,
                          32'h0000_0000};

  dicr_regs uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .test_fail_bits,
    .fifo_a_wr_ptr, .fifo_b_wr_ptr, .fifo_a_two_apart(ev[5]), .fifo_a_one_apart(ev[4]),
    .fifo_a_collision(ev[3]), .fifo_b_two_apart(ev[2]), .fifo_b_one_apart(ev[1]),
    .fifo_b_collision(ev[0]), .receiver_enable, .data_delay_a, .clk_delay_a, .data_delay_b,
    .clk_delay_b, .ext_ref_select, .dual_clock_enable, .iotest_enable,
    .two_apart_alarm_enable, .one_apart_alarm_enable, .collision_alarm_enable);

  always #50 hclk = ~hclk;

  task automatic wrap_up();
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one single transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  task automatic pulse(input logic [13:0] t, input logic [5:0] e);
    test_fail_bits <= t;
    ev             <= e;
    @(posedge hclk);
    test_fail_bits <= 14'h0000;
    ev             <= 6'h00;
  endtask

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk({18'h0_0000, receiver_enable}, 32'h0000_3fff);
    chk({28'h000_0000, iotest_enable, two_apart_alarm_enable, one_apart_alarm_enable,
         collision_alarm_enable}, 32'h0000_0007);
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    wr(32'h0000_0008, 32'hffff_ffff);
    rd(32'h0000_0008, 32'h0000_3fff);
    wr(32'h0000_000c, 32'hffff_ffff);
    rd(32'h0000_000c, 32'h0000_fff9);
    wr(32'h0000_000c, 32'h0000_ad69);
    rd(32'h0000_000c, 32'h0000_ad69);
    chk({16'h0000, data_delay_a, clk_delay_a, data_delay_b, clk_delay_b, ext_ref_select,
         2'b00, dual_clock_enable}, 32'h0000_ad69);
    wr(32'h0000_000c, 32'h0000_ad68);
    // written value reaches the outputs at the edge that ends the data phase
    @(posedge hclk);
    chk({31'h0000_0000, dual_clock_enable}, 32'h0000_0000);
    wr(32'h0000_0008, 32'h0000_3ffc);
    @(posedge hclk);
    chk({18'h0_0000, receiver_enable}, 32'h0000_3ffc);
    wr(32'h0000_0040, 32'hffff_ffff);
    rd(32'h0000_0040, 32'h0000_0000);
    rd(32'h0000_0009, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    pulse(14'h2001, 6'h00);
    rd(32'h0000_0010, 32'h0000_0000);
    wr(32'h0000_0004, 32'hffff_ffff);
    rd(32'h0000_0004, 32'h0000_800e);
    pulse(14'h2001, 6'h00);
    rd(32'h0000_0010, 32'h0000_2001);
    wr(32'h0000_0010, 32'h0000_0001);
    rd(32'h0000_0010, 32'h0000_2000);
    for (int i = 1; i < 4; i++) begin
      wr(32'h0000_0004, 32'h0000_0001 << i);
      pulse(14'h0000, 6'h3f);
      rd(32'h0000_0014, 32'h0000_0900 << (3 - i));
      wr(32'h0000_0014, 32'h0000_ffff);
    end
    wr(32'h0000_0004, 32'h0000_0000);
    pulse(14'h0000, 6'h3f);
    rd(32'h0000_0014, 32'h0000_0000);
    fifo_a_wr_ptr <= 8'h00;
    fifo_b_wr_ptr <= 8'h00;
    wr(32'h0000_0014, 32'h0000_c000);
    rd(32'h0000_0014, 32'h0000_c000);
    fifo_a_wr_ptr <= 8'h01;
    fifo_b_wr_ptr <= 8'h01;
    wr(32'h0000_0014, 32'h0000_c000);
    rd(32'h0000_0014, 32'h0000_0000);
    wrap_up();
  end
endmodule
